// File: drf_pkg.sv
package drf_pkg;

  // ************************************************************
  // widths and depths
  // ************************************************************
  localparam int DRF_DATA_W     = 8;
  localparam int DRF_FIFO_DEPTH = 4;

  // ************************************************************
  // status register field positions
  // ************************************************************
  localparam int DRF_STAT_W      = 8;
  localparam int DRF_STAT_TX_BIT = 4;
  localparam int DRF_STAT_RX_BIT = 3;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic                  DRF_TX_FLAG_RST = 1'h1;
  localparam logic                  DRF_RX_FLAG_RST = 1'h0;
  localparam logic [DRF_DATA_W-1:0] DRF_DATA_RST    = 8'h00;

  // pair of data-ready flags carried together
  typedef struct packed {
    logic tx_ready_flag;
    logic rx_ready_flag;
  } drf_flags_t;

  localparam drf_flags_t DRF_FLAGS_RST = '{tx_ready_flag: DRF_TX_FLAG_RST,
                                           rx_ready_flag: DRF_RX_FLAG_RST};

endpackage : drf_pkg

// File: drf_fifo.sv
// small flop-based fifo with valid/ready on both sides and a flush
module drf_fifo
  import drf_pkg::*;
#(
  parameter int WIDTH = DRF_DATA_W,
  parameter int DEPTH = DRF_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_srst,
  input  wire logic             i_flush,
  // fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    wr_ptr_d;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW-1:0]    rd_ptr_d;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             push;
  logic             pop;

  // pointer step with wrap, since depth need not be a power of two
  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      return '0;
    end
    return p + AW'(1);
  endfunction : ptr_next

  // ************************************************************
  // handshakes
  // ************************************************************
  assign o_in_ready  = (count_q != (AW+1)'(DEPTH));
  assign o_out_valid = (count_q != '0);
  assign o_out_data  = mem_q[rd_ptr_q];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // next state of storage and pointers
  always_comb begin
    mem_d    = mem_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d  = count_q;
    if (i_flush) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      count_d  = '0;
    end else begin
      if (push) begin
        mem_d[wr_ptr_q] = i_in_data;
        wr_ptr_d        = ptr_next(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_d = ptr_next(rd_ptr_q);
      end
      if (push && !pop) begin
        count_d = count_q + (AW+1)'(1);
      end else if (pop && !push) begin
        count_d = count_q - (AW+1)'(1);
      end
    end
  end

  // register stage
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
      mem_q    <= mem_d;
    end
  end

endmodule : drf_fifo

// File: drf_data_ready_flags.sv
// What this block does
// R01: set transmit-ready flag (status bit 4) when holding register copies into shift register.
// R02: clear transmit-ready flag when host writes the transmit holding register.
// R03: force transmit-ready flag to 1 while module is in or enters reset.
// R04: transmit-ready interrupt request follows the transmit-ready flag.
// R05: set receive-ready flag (status bit 3) when a received word reaches holding register.
// R06: clear receive-ready flag when host reads the receive holding register.
// R07: writing 1 to receive-ready bit clears it; writing 0 leaves it.
// R08: clear receive-ready flag on module reset via run bit or chip reset.
// R09: receive-ready interrupt request follows the receive-ready flag.
// R10: reading the interrupt source register leaves both flags unchanged.
// R11: a transfer event in the same cycle as a clearing access wins and sets the flag.
module drf_data_ready_flags
  import drf_pkg::*;
(
  // clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_srst,
  // mode control
  input  wire logic                  i_module_run_bit,
  // host: transmit holding register write
  input  wire logic                  i_tx_holding_wr,
  input  wire logic [DRF_DATA_W-1:0] i_tx_holding_wdata,
  // host: receive holding register read
  input  wire logic                  i_rx_holding_rd,
  output logic [DRF_DATA_W-1:0]      o_rx_holding_reg,
  // host: status register write and read
  input  wire logic                  i_status_wr,
  input  wire logic [DRF_STAT_W-1:0] i_status_wdata,
  output logic [DRF_STAT_W-1:0]      o_status,
  // host: interrupt source register read
  input  wire logic                  i_isrc_rd,
  // host: flags and interrupt requests
  output drf_flags_t                 o_flags,
  output logic                       o_transmit_ready_request,
  output logic                       o_receive_ready_request,
  // serial engine: transmit side
  input  wire logic                  i_tx_shift_load,
  output logic [DRF_DATA_W-1:0]      o_tx_shift_reg,
  // serial engine: receive side
  input  wire logic                  i_rx_word_valid,
  input  wire logic [DRF_DATA_W-1:0] i_rx_word,
  output logic                       o_rx_word_ready
);

  // ************************************************************
  // state
  // ************************************************************
  // transmit group
  logic                  tx_flag_q;
  logic                  tx_flag_d;
  logic [DRF_DATA_W-1:0] tx_holding_reg_q;
  logic [DRF_DATA_W-1:0] tx_holding_reg_d;
  logic [DRF_DATA_W-1:0] tx_shift_reg_q;
  logic [DRF_DATA_W-1:0] tx_shift_reg_d;
  // receive group
  logic                  rx_flag_q;
  logic                  rx_flag_d;
  logic [DRF_DATA_W-1:0] rx_holding_reg_q;
  logic [DRF_DATA_W-1:0] rx_holding_reg_d;
  // control and fifo drain side
  logic                  mod_reset;
  logic                  rx_clear;
  logic                  fifo_valid;
  logic [DRF_DATA_W-1:0] fifo_data;
  logic                  rx_pop;
  logic                  rx_take;

  // ************************************************************
  // flag update rule
  // ************************************************************
  // one place decides the next value of either flag: reset first, then a
  // set event beats a clear in the same cycle, so no data-ready event is
  // lost when the host happens to access the register at that moment
  function automatic logic flag_next(
    input logic rst_val,
    input logic in_reset,
    input logic cur,
    input logic set_ev,
    input logic clr_ev
  );
    if (in_reset) begin
      return rst_val;
    end
    if (set_ev) begin
      return 1'h1;                                     // R11
    end
    if (clr_ev) begin
      return 1'h0;
    end
    return cur;
  endfunction : flag_next

  // ************************************************************
  // control
  // ************************************************************

  // module reset is chip reset or the run bit held at 0
  assign mod_reset = i_srst || !i_module_run_bit;

  // host clears of the receive flag; interrupt source reads are not one of them
  assign rx_clear = i_rx_holding_rd                                   // R06 R10
                 || (i_status_wr && i_status_wdata[DRF_STAT_RX_BIT]); // R07

  // take the next word when the holding register is free or being cleared now
  // interrupt source reads are left out on purpose: polling must never cost an event
  assign rx_pop = !mod_reset && (!rx_flag_q || rx_clear); // R11

  // a word only moves when the fifo has one to give
  assign rx_take = rx_pop && fifo_valid;

  // ************************************************************
  // receive path fifo
  // ************************************************************
  // the fifo absorbs a burst while the host is slow to read; once full,
  // the engine sees ready low and must stall
  drf_fifo #(
    .WIDTH (DRF_DATA_W),
    .DEPTH (DRF_FIFO_DEPTH)
  ) drf_fifo_i (
    .i_sys_clk   (i_sys_clk),
    .i_srst      (i_srst),
    .i_flush     (mod_reset),
    .i_in_valid  (i_rx_word_valid),
    .i_in_data   (i_rx_word),
    .o_in_ready  (o_rx_word_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (rx_pop)
  );

  // ************************************************************
  // transmit group
  // ************************************************************
  // host write clears the flag, engine load sets it; a load in the same
  // cycle as a write moves the old word out and keeps the new one waiting
  always_comb begin
    tx_holding_reg_d = tx_holding_reg_q;
    tx_shift_reg_d   = tx_shift_reg_q;
    if (!mod_reset && i_tx_holding_wr) begin
      tx_holding_reg_d = i_tx_holding_wdata;
    end
    if (!mod_reset && i_tx_shift_load) begin
      tx_shift_reg_d = tx_holding_reg_q;               // old word moves out
    end
    tx_flag_d = flag_next(DRF_TX_FLAG_RST, mod_reset, tx_flag_q,
                          i_tx_shift_load, i_tx_holding_wr); // R01 R02 R03 R11
  end

  // data registers keep their contents over a run-bit reset, so software
  // that toggles the run bit must not expect the holding words to clear
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      tx_flag_q        <= DRF_TX_FLAG_RST;             // R03
      tx_holding_reg_q <= DRF_DATA_RST;
      tx_shift_reg_q   <= DRF_DATA_RST;
    end else begin
      tx_flag_q        <= tx_flag_d;
      tx_holding_reg_q <= tx_holding_reg_d;
      tx_shift_reg_q   <= tx_shift_reg_d;
    end
  end

  // ************************************************************
  // receive group
  // ************************************************************
  // host read or a written 1 clears the flag, a word from the fifo sets it;
  // a clear that meets a waiting word hands that word over in one cycle
  always_comb begin
    rx_holding_reg_d = rx_holding_reg_q;
    if (rx_take) begin
      rx_holding_reg_d = fifo_data;
    end
    rx_flag_d = flag_next(DRF_RX_FLAG_RST, mod_reset, rx_flag_q,
                          rx_take, rx_clear);           // R05 R06 R07 R08 R11
  end

  // receive holding word survives a run-bit reset like the transmit side
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rx_flag_q        <= DRF_RX_FLAG_RST;             // R08
      rx_holding_reg_q <= DRF_DATA_RST;
    end else begin
      rx_flag_q        <= rx_flag_d;
      rx_holding_reg_q <= rx_holding_reg_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // requests are the flags themselves, so polling and interrupts agree
  assign o_transmit_ready_request = tx_flag_q;                   // R04
  assign o_receive_ready_request  = rx_flag_q;                   // R09
  assign o_flags                  = '{tx_ready_flag: tx_flag_q,
                                      rx_ready_flag: rx_flag_q};
  assign o_tx_shift_reg           = tx_shift_reg_q;
  assign o_rx_holding_reg         = rx_holding_reg_q;

  // status image: only the two ready bits live here, the rest read as zero
  always_comb begin
    o_status                  = '0;
    o_status[DRF_STAT_TX_BIT] = tx_flag_q;                 // R01
    o_status[DRF_STAT_RX_BIT] = rx_flag_q;                 // R05
  end

endmodule : drf_data_ready_flags

// File: drf_flags_chk.sv
// watches the flag outputs against host strobes and engine events
module drf_flags_chk
  import drf_pkg::*;
(
  // clock and reset
  input wire logic                  i_sys_clk,
  input wire logic                  i_srst,
  // host and engine strobes
  input wire logic                  i_module_run_bit,
  input wire logic                  i_tx_holding_wr,
  input wire logic                  i_rx_holding_rd,
  input wire logic                  i_status_wr,
  input wire logic [DRF_STAT_W-1:0] i_status_wdata,
  input wire logic                  i_isrc_rd,
  input wire logic                  i_tx_shift_load,
  // flag outputs
  input wire drf_flags_t            o_flags,
  input wire logic [DRF_STAT_W-1:0] o_status,
  input wire logic                  o_transmit_ready_request,
  input wire logic                  o_receive_ready_request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  chk_tx_set_load:
    assert property (i_tx_shift_load |=> o_flags.tx_ready_flag) else $error("tx not set");
  chk_tx_write_clear:
    assert property (i_tx_holding_wr && !i_tx_shift_load && i_module_run_bit
      |=> !o_flags.tx_ready_flag && !o_transmit_ready_request) else $error("tx not cleared");
  chk_tx_fall_cause:
    assert property ($fell(o_flags.tx_ready_flag) |-> $past(i_tx_holding_wr))
      else $error("tx fell without write");
  chk_run_low_reset:
    assert property (!i_module_run_bit |=> o_status == 8'h10) else $error("run low no reset");
  chk_tx_request:
    assert property (o_transmit_ready_request == o_status[4] && o_status[4] == o_flags[1])
      else $error("tx request mismatch");
  chk_rx_request:
    assert property (o_receive_ready_request == o_status[3] && o_status[3] == o_flags[0])
      else $error("rx request mismatch");
  chk_status_spare:
    assert property ((o_status & 8'hE7) == 8'h00) else $error("spare status bits set");
  chk_rx_fall_cause:
    assert property ($fell(o_flags.rx_ready_flag) |-> $past(i_rx_holding_rd)
      || ($past(i_status_wr) && $past(i_status_wdata[3])) || !$past(i_module_run_bit)
      || $past(i_srst))
      else $error("rx fell without cause");
  chk_wr0_keeps_rx:
    assert property (i_status_wr && !i_status_wdata[3] && !i_rx_holding_rd && i_module_run_bit
      && o_flags.rx_ready_flag |=> o_flags.rx_ready_flag) else $error("rx lost on zero");
  chk_isrc_quiet:
    assert property (i_isrc_rd && !i_tx_holding_wr && !i_rx_holding_rd && !i_status_wr
      && i_module_run_bit |=> !$fell(o_flags.tx_ready_flag) && !$fell(o_flags.rx_ready_flag))
      else $error("isrc read changed a flag");
endmodule : drf_flags_chk

// File: drf_engine_model.sv
// serial engine stand-in: offers one received word, holds it until taken
module drf_engine_model
  import drf_pkg::*;
(
  // clock and command
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_srst,
  input  wire logic                  i_go,
  input  wire logic [DRF_DATA_W-1:0] i_word,
  // handshake to the block
  input  wire logic                  i_ready,
  output logic                       o_valid,
  output logic [DRF_DATA_W-1:0]      o_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // released data is inverted so a stale word never looks valid
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_valid <= 1'b0;
      o_word  <= 8'h00;
    end else if (o_valid && i_ready) begin
      o_valid <= 1'b0;
      o_word  <= ~o_word;
    end else if (i_go && !o_valid) begin
      o_valid <= 1'b1;
      o_word  <= i_word;
    end
  end
endmodule : drf_engine_model

// File: drf_data_ready_flags_bench.sv
module drf_data_ready_flags_bench;
  import drf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, srst = 1'b1, run = 1'b1, txwr = 1'b0, rxrd = 1'b0, stwr = 1'b0;
  logic       isrd = 1'b0, load = 1'b0, go = 1'b0, rdy, ev, trq, rrq;
  logic [7:0] txd = 8'h00, stwd = 8'h00, gw = 8'h00, rxh, st, shift, ew;
  drf_flags_t fl;
  int         n_mismatch = 0, checks_done = 0;
  always #20 clk = ~clk;
  drf_data_ready_flags drf_data_ready_flags_i (.i_sys_clk(clk), .i_srst(srst),
    .i_module_run_bit(run), .i_tx_holding_wr(txwr), .i_tx_holding_wdata(txd),
    .i_rx_holding_rd(rxrd), .o_rx_holding_reg(rxh), .i_status_wr(stwr),
    .i_status_wdata(stwd), .o_status(st), .i_isrc_rd(isrd), .o_flags(fl),
    .o_transmit_ready_request(trq), .o_receive_ready_request(rrq), .i_tx_shift_load(load),
    .o_tx_shift_reg(shift), .i_rx_word_valid(ev), .i_rx_word(ew), .o_rx_word_ready(rdy));
  drf_engine_model drf_engine_model_i (.i_sys_clk(clk), .i_srst(srst), .i_go(go), .i_word(gw),
    .i_ready(rdy), .o_valid(ev), .o_word(ew));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic offer(input logic [7:0] w);
    @(posedge clk);
    go <= 1'b1;
    gw <= w;
    @(posedge clk);
    go <= 1'b0;
    tick(3);
  endtask : offer
  // one-cycle host strobe: 0 tx write, 1 rx read, 2 status write, 3 source read
  task automatic pulse(input int sel, input logic [7:0] d);
    @(posedge clk);
    txd  <= d;
    stwd <= d;
    txwr <= (sel == 0);
    rxrd <= (sel == 1);
    stwr <= (sel == 2);
    isrd <= (sel == 3);
    @(posedge clk);
    txwr <= 1'b0;
    rxrd <= 1'b0;
    stwr <= 1'b0;
    isrd <= 1'b0;
    #1;
  endtask : pulse
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_tx;
    pulse(0, 8'h5A);
    cmp(st, 8'h00);
    @(posedge clk);
    load <= 1'b1;
    txwr <= 1'b1;
    txd  <= 8'h3C;
    @(posedge clk);
    load <= 1'b0;
    txwr <= 1'b0;
    #1 cmp(shift, 8'h5A);
    cmp(st, 8'h10);
  endtask : t_tx
  // fill holding plus fifo until refused, then drain in order
  task automatic t_rx;
    for (int k = 0; k < 5; k++) begin
      offer(8'hA0 + 8'(k));
    end
    #1 cmp({7'h00, rdy}, 8'h00);
    cmp(st, 8'h18);
    for (int k = 0; k < 5; k++) begin
      cmp(rxh, 8'hA0 + 8'(k));
      pulse(1, 8'h00);
      tick(2);
      #1;
    end
    cmp(st, 8'h10);
  endtask : t_rx
  task automatic t_clr;
    offer(8'h77);
    pulse(2, 8'hF7);
    cmp(st, 8'h18);
    pulse(3, 8'h00);
    cmp(st, 8'h18);
    pulse(2, 8'h08);
    cmp(st, 8'h10);
  endtask : t_clr
  task automatic t_run;
    offer(8'h42);
    pulse(0, 8'h11);
    cmp(st, 8'h08);
    @(posedge clk);
    run <= 1'b0;
    @(posedge clk);
    run <= 1'b1;
    #1 cmp(st, 8'h10);
    cmp(rxh, 8'h42);
    offer(8'h43);
    pulse(0, 8'h22);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1 cmp(st, 8'h10);
    cmp(rxh, DRF_DATA_RST);
    tick(2);
  endtask : t_run
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    tick(8);
    srst <= 1'b0;
    t_tx;
    t_rx;
    t_clr;
    t_run;
    tally_and_finish;
  end
  // watchdog: the tests need under a hundred cycles, the limit is 2000
  initial begin
    #80000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule : drf_data_ready_flags_bench
bind drf_data_ready_flags drf_flags_chk drf_flags_chk_i (.i_sys_clk(i_sys_clk),
  .i_srst(i_srst), .i_module_run_bit(i_module_run_bit), .i_tx_holding_wr(i_tx_holding_wr),
  .i_rx_holding_rd(i_rx_holding_rd), .i_status_wr(i_status_wr),
  .i_status_wdata(i_status_wdata), .i_isrc_rd(i_isrc_rd), .i_tx_shift_load(i_tx_shift_load),
  .o_flags(o_flags), .o_status(o_status), .o_transmit_ready_request(o_transmit_ready_request),
  .o_receive_ready_request(o_receive_ready_request));
